// ### rtl/ugf_cts_gate.sv
`timescale 1ns/10ps
`default_nettype none
module ugf_cts_gate
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic autoCtsEn,
    input wire logic ctsN,
    input wire logic charBoundary,
    output logic txHalt
);

    logic txHalt_q;
    logic txHalt_d;

    // The halt only changes between characters so a frame is never cut short.
    // halt on high clear-to-send
    assign txHalt_d = charBoundary ? (autoCtsEn & ctsN) : txHalt_q;

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            txHalt_q <= 1'b0;
        else
            txHalt_q <= txHalt_d;
    end

    assign txHalt = txHalt_q;

endmodule : ugf_cts_gate
`default_nettype wire

// ### rtl/ugf_pin_port.sv
`timescale 1ns/10ps
`default_nettype none
module ugf_pin_port
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [ugf_pkg::PIN_NUM-1:0] pinIn,
    input wire logic [ugf_pkg::PIN_NUM-1:0] levelOut,
    input wire logic [ugf_pkg::PIN_NUM-1:0] irqEnable,
    input wire logic [ugf_pkg::PIN_NUM-1:0] tristate,
    input wire logic [ugf_pkg::PIN_NUM-1:0] polarity,
    input wire logic [ugf_pkg::PIN_NUM-1:0] direction,
    output logic [ugf_pkg::PIN_NUM-1:0] levelRead,
    output logic [ugf_pkg::PIN_NUM-1:0] pinEvent,
    output logic [ugf_pkg::PIN_NUM-1:0] pinOut,
    output logic [ugf_pkg::PIN_NUM-1:0] pinOe
);
    import ugf_pkg::*;

    logic [PIN_NUM-1:0] prevIn_q;

    genvar p;
    generate
        for (p = 0; p < PIN_NUM; p++)
        begin : gPin
            assign levelRead[p] = pinIn[p] ^ polarity[p];
            assign pinEvent[p] = direction[p] & irqEnable[p] & ~(prevIn_q[p] ^ polarity[p])
                & (pinIn[p] ^ polarity[p]);
            assign pinOe[p] = ~direction[p] & ~tristate[p];
            assign pinOut[p] = levelOut[p];

            always_ff @(posedge clk_sys)
            begin
                if (srst)
                    prevIn_q[p] <= pinIn[p] ^ 1'b0;
                else
                    prevIn_q[p] <= pinIn[p];
            end
        end
    endgenerate

endmodule : ugf_pin_port
`default_nettype wire

// ### rtl/ugf_pkg.sv
package ugf_pkg;

    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam int PIN_NUM = 8;
    localparam int REG_NUM = 29;

    localparam logic [ADDR_W-1:0] OFS_DIV_LOW = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_DIV_HIGH = 5'h01;
    localparam logic [ADDR_W-1:0] OFS_FRAC_DIV = 5'h02;
    localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 5'h03;
    localparam logic [ADDR_W-1:0] OFS_FIFO_CTRL = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 5'h05;
    localparam logic [ADDR_W-1:0] OFS_LINE_CTRL = 5'h06;
    localparam logic [ADDR_W-1:0] OFS_MODEM_CTRL = 5'h07;
    localparam logic [ADDR_W-1:0] OFS_LINE_STATUS = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_MODEM_STATUS = 5'h09;
    localparam logic [ADDR_W-1:0] OFS_SCRATCH = 5'h0A;
    localparam logic [ADDR_W-1:0] OFS_FLOW_HYST = 5'h0B;
    localparam logic [ADDR_W-1:0] OFS_SPECIAL_FUNC = 5'h0C;
    localparam logic [ADDR_W-1:0] OFS_ENH_MODE_SEL = 5'h0D;
    localparam logic [ADDR_W-1:0] OFS_FIFO_LEVEL = 5'h0E;
    localparam logic [ADDR_W-1:0] OFS_TRIGGER_LEVEL = 5'h0F;
    localparam logic [ADDR_W-1:0] OFS_FEATURE_CTRL = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_ENH_FEATURE = 5'h11;
    localparam logic [ADDR_W-1:0] OFS_RESUME_ONE = 5'h12;
    localparam logic [ADDR_W-1:0] OFS_RESUME_TWO = 5'h13;
    localparam logic [ADDR_W-1:0] OFS_PAUSE_ONE = 5'h14;
    localparam logic [ADDR_W-1:0] OFS_PAUSE_TWO = 5'h15;
    localparam logic [ADDR_W-1:0] OFS_PIN_LEVEL = 5'h16;
    localparam logic [ADDR_W-1:0] OFS_PIN_IRQ_EN = 5'h17;
    localparam logic [ADDR_W-1:0] OFS_PIN_TRISTATE = 5'h18;
    localparam logic [ADDR_W-1:0] OFS_PIN_POLARITY = 5'h19;
    localparam logic [ADDR_W-1:0] OFS_PIN_DIRECTION = 5'h1A;
    localparam logic [ADDR_W-1:0] OFS_PIN_EVT_STATUS = 5'h1B;
    localparam logic [ADDR_W-1:0] OFS_PIN_EVT_MASK = 5'h1C;

    localparam logic [DATA_W-1:0] RST_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] RST_DIV_LOW = 8'h01;
    localparam logic [DATA_W-1:0] RST_DIV_HIGH = 8'h00;
    localparam logic [DATA_W-1:0] RST_IRQ_STATUS = 8'h01;
    localparam logic [DATA_W-1:0] IRQ_STATUS_PENDING = 8'h00;
    localparam logic [DATA_W-1:0] RST_LINE_STATUS = 8'h60;
    localparam logic [DATA_W-1:0] RST_SCRATCH = 8'hFF;
    localparam logic [DATA_W-1:0] RST_TRIGGER_LEVEL = 8'h01;
    localparam logic [DATA_W-1:0] RST_PIN_DIRECTION = 8'hFF;

    localparam int EFR_AUTO_CTS_BIT = 7;
    localparam int SFR_NINE_BIT_BIT = 0;
    localparam int MCR_DTR_BIT = 0;
    localparam int MCR_RTS_BIT = 1;

    // Entries that only software writes; the others are status or are computed, or the pin event mask, which is kept in its own register.
    localparam logic [REG_NUM-1:0] RW_MASK = 29'h07FF_BCDF;

    function automatic logic [DATA_W-1:0] resetValue(input logic [ADDR_W-1:0] idx);
        logic [DATA_W-1:0] val;
        val = RST_ZERO;
        unique case (idx)
            OFS_DIV_LOW: val = RST_DIV_LOW;
            OFS_DIV_HIGH: val = RST_DIV_HIGH;
            OFS_SCRATCH: val = RST_SCRATCH;
            OFS_TRIGGER_LEVEL: val = RST_TRIGGER_LEVEL;
            OFS_PIN_DIRECTION: val = RST_PIN_DIRECTION;
            default: val = RST_ZERO;
        endcase
        return val;
    endfunction : resetValue

endpackage : ugf_pkg

// ### rtl/ugf_top.sv
// The address map and the plain strobed port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module ugf_top
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic pwrOnRst,
    input wire logic [ugf_pkg::ADDR_W-1:0] regAddr,
    input wire logic [ugf_pkg::DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [ugf_pkg::DATA_W-1:0] regRdData,
    input wire logic ctsN,
    input wire logic dsrN,
    input wire logic riN,
    input wire logic cdN,
    input wire logic txSerialIn,
    input wire logic txCharBoundary,
    input wire logic [ugf_pkg::DATA_W-1:0] rxData,
    input wire logic rxValid,
    input wire logic [ugf_pkg::PIN_NUM-1:0] pinIn,
    output logic serialTx,
    output logic txHalt,
    output logic rtsN,
    output logic dtrN,
    output logic irq,
    output logic irqN,
    output logic addrMatch,
    output logic [ugf_pkg::PIN_NUM-1:0] pinOut,
    output logic [ugf_pkg::PIN_NUM-1:0] pinOe
);
    import ugf_pkg::*;

    logic [DATA_W-1:0] regs_q [0:REG_NUM-1];
    logic [REG_NUM-1:0] wrHit;
    logic [DATA_W-1:0] rdData_q;
    logic [DATA_W-1:0] rdData_d;
    logic [DATA_W-1:0] rdStored;
    logic addrInRange;

    logic [PIN_NUM-1:0] evtStatus_q;
    logic [PIN_NUM-1:0] evtStatus_d;
    logic [PIN_NUM-1:0] evtMask_q;
    logic [PIN_NUM-1:0] pinEvent;
    logic [PIN_NUM-1:0] levelRead;
    logic [PIN_NUM-1:0] pinOutW;
    logic [PIN_NUM-1:0] pinOeW;
    logic [PIN_NUM-1:0] pinOut_q;
    logic [PIN_NUM-1:0] pinOe_q;
    logic evtWr;
    logic evtMaskWr;
    logic irqAny;
    logic irq_q;
    logic irqN_q;

    logic [3:0] modemIn;
    logic [3:0] modemPrev_q;
    logic [3:0] modemDelta_q;
    logic [3:0] modemDelta_d;
    logic msRead;
    logic [DATA_W-1:0] modemStatus;
    logic [DATA_W-1:0] irqStatus;

    logic autoCtsEn;
    logic nineBitMode;
    logic txHaltW;
    logic serialTx_q;
    logic rtsN_q;
    logic dtrN_q;
    logic addrMatch_q;
    logic addrMatch_d;

    assign addrInRange = (regAddr < ADDR_W'(REG_NUM));

    // Generic register storage; status entries are masked out of the write path.
    genvar i;
    generate
        for (i = 0; i < REG_NUM; i++)
        begin : gReg
            localparam logic [ADDR_W-1:0] IDX = ADDR_W'(i);
            localparam bit POWER_UP_ONLY = (IDX == OFS_DIV_LOW) || (IDX == OFS_DIV_HIGH);
            assign wrHit[i] = regWr & (regAddr == IDX) & RW_MASK[i];

            always_ff @(posedge clk_sys)
            begin
                if (pwrOnRst || (srst && !POWER_UP_ONLY))
                    regs_q[i] <= resetValue(IDX);
                else if (wrHit[i])
                    regs_q[i] <= regWrData;
            end
        end
    endgenerate

    assign autoCtsEn = regs_q[OFS_ENH_FEATURE][EFR_AUTO_CTS_BIT];
    assign nineBitMode = regs_q[OFS_SPECIAL_FUNC][SFR_NINE_BIT_BIT];

    ugf_cts_gate uCtsGate
    (
        .clk_sys(clk_sys),
        .srst(srst),
        .autoCtsEn(autoCtsEn),
        .ctsN(ctsN),
        .charBoundary(txCharBoundary),
        .txHalt(txHaltW)
    );

    ugf_pin_port uPinPort
    (
        .clk_sys(clk_sys),
        .srst(srst),
        .pinIn(pinIn),
        .levelOut(regs_q[OFS_PIN_LEVEL]),
        .irqEnable(regs_q[OFS_PIN_IRQ_EN]),
        .tristate(regs_q[OFS_PIN_TRISTATE]),
        .polarity(regs_q[OFS_PIN_POLARITY]),
        .direction(regs_q[OFS_PIN_DIRECTION]),
        .levelRead(levelRead),
        .pinEvent(pinEvent),
        .pinOut(pinOutW),
        .pinOe(pinOeW)
    );

    // Pin event status is sticky; a new edge wins over a write-one-to-clear.
    assign evtWr = regWr & (regAddr == OFS_PIN_EVT_STATUS);
    assign evtMaskWr = regWr & (regAddr == OFS_PIN_EVT_MASK);
    assign evtStatus_d = (evtStatus_q & ~(evtWr ? regWrData : RST_ZERO)) | pinEvent;
    assign irqAny = |(evtStatus_q & evtMask_q);

    // address match against second pause char
    assign addrMatch_d = nineBitMode & rxValid & (rxData == regs_q[OFS_PAUSE_TWO]);

    // upper nibble is complement of inputs
    assign modemIn = {cdN, riN, dsrN, ctsN};
    assign msRead = regRd & (regAddr == OFS_MODEM_STATUS);
    assign modemDelta_d = ((msRead ? 4'h0 : modemDelta_q) | (modemIn ^ modemPrev_q));
    assign modemStatus = {~modemIn, modemDelta_q};
    assign irqStatus = irqAny ? IRQ_STATUS_PENDING : RST_IRQ_STATUS;

    // true level read with polarity 0
    // inverted level read with polarity 1
    assign rdStored = regs_q[regAddr];
    assign rdData_d = !regRd ? RST_ZERO :
        !addrInRange ? RST_ZERO :
        (regAddr == OFS_IRQ_STATUS) ? irqStatus :
        (regAddr == OFS_LINE_STATUS) ? RST_LINE_STATUS :
        (regAddr == OFS_MODEM_STATUS) ? modemStatus :
        (regAddr == OFS_FIFO_LEVEL) ? RST_ZERO :
        (regAddr == OFS_PIN_LEVEL) ? levelRead :
        (regAddr == OFS_PIN_EVT_STATUS) ? evtStatus_q :
        (regAddr == OFS_PIN_EVT_MASK) ? evtMask_q :
        rdStored;

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            rdData_q <= RST_ZERO;
            evtStatus_q <= RST_ZERO;
            evtMask_q <= RST_ZERO;
        end
        else
        begin
            rdData_q <= rdData_d;
            evtStatus_q <= evtStatus_d;
            if (evtMaskWr)
                evtMask_q <= regWrData;
        end
    end

    // The delta bits start clear because the previous sample is loaded at reset.
    // lower nibble zero after reset
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            modemDelta_q <= 4'h0;
            modemPrev_q <= modemIn;
        end
        else
        begin
            modemDelta_q <= modemDelta_d;
            modemPrev_q <= modemIn;
        end
    end

    // hold the line idle while halted
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            serialTx_q <= 1'b1;
            rtsN_q <= 1'b1;
            dtrN_q <= 1'b1;
            irq_q <= 1'b0;
            irqN_q <= 1'b1;
            addrMatch_q <= 1'b0;
            pinOut_q <= RST_ZERO;
            pinOe_q <= RST_ZERO;
        end
        else
        begin
            serialTx_q <= txHaltW | txSerialIn;
            rtsN_q <= ~regs_q[OFS_MODEM_CTRL][MCR_RTS_BIT];
            dtrN_q <= ~regs_q[OFS_MODEM_CTRL][MCR_DTR_BIT];
            irq_q <= irqAny;
            irqN_q <= ~irqAny;
            addrMatch_q <= addrMatch_d;
            pinOut_q <= pinOutW;
            pinOe_q <= pinOeW;
        end
    end

    assign regRdData = rdData_q;
    assign serialTx = serialTx_q;
    assign txHalt = txHaltW;
    assign rtsN = rtsN_q;
    assign dtrN = dtrN_q;
    assign irq = irq_q;
    assign irqN = irqN_q;
    assign addrMatch = addrMatch_q;
    assign pinOut = pinOut_q;
    assign pinOe = pinOe_q;

endmodule : ugf_top
`default_nettype wire

// ### testbench/uart_gpio_flow_reset_config_bench.sv
`timescale 1ns/10ps
`default_nettype none
module uart_gpio_flow_reset_config_bench;
    import ugf_pkg::*;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic pwrOnRst = 1'b1;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [DATA_W-1:0] regWrData = '0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic pauseReq = 1'b0;
    logic txSerialIn = 1'b1;
    logic txCharBoundary = 1'b1;
    logic [DATA_W-1:0] rxData = '0;
    logic rxValid = 1'b0;
    logic [PIN_NUM-1:0] pinIn = 8'h06;
    logic [DATA_W-1:0] regRdData;
    logic ctsN, serialTx, txHalt, rtsN, dtrN, irq, irqN, addrMatch;
    logic [PIN_NUM-1:0] pinOut, pinOe;
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    localparam logic [ADDR_W-1:0] ZERO_REGS [18] = '{OFS_FRAC_DIV, OFS_IRQ_ENABLE,
        OFS_FIFO_CTRL, OFS_LINE_CTRL, OFS_MODEM_CTRL, OFS_FLOW_HYST, OFS_SPECIAL_FUNC,
        OFS_ENH_MODE_SEL, OFS_FIFO_LEVEL, OFS_FEATURE_CTRL, OFS_ENH_FEATURE, OFS_RESUME_ONE,
        OFS_RESUME_TWO, OFS_PAUSE_ONE, OFS_PAUSE_TWO, OFS_PIN_IRQ_EN, OFS_PIN_TRISTATE,
        OFS_PIN_POLARITY};
    always #4 clk_sys = ~clk_sys;
    ugf_cts_peer peer (.clk_sys, .srst, .pauseReq, .ctsN);
    ugf_top dut (.clk_sys, .srst, .pwrOnRst, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
        .ctsN, .dsrN(1'b0), .riN(1'b1), .cdN(1'b1), .txSerialIn, .txCharBoundary, .rxData,
        .rxValid, .pinIn, .serialTx, .txHalt, .rtsN, .dtrN, .irq, .irqN, .addrMatch, .pinOut,
        .pinOe);
    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            num_errors++;
            report_and_stop();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk_sys);
        regWr <= 1'b0;
        @(posedge clk_sys);
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1;
        check(regRdData, exp);
        @(posedge clk_sys);
    endtask : rd
    task automatic wait_settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : wait_settle
    task automatic reset_values;
        #1;
        check({4'h0, serialTx, rtsN, dtrN, irqN}, 8'h0F);
        foreach (ZERO_REGS[i]) rd(ZERO_REGS[i], RST_ZERO);
        rd(OFS_DIV_LOW, 8'h01);
        rd(OFS_DIV_HIGH, 8'h00);
        rd(OFS_IRQ_STATUS, 8'h01);
        rd(OFS_SCRATCH, 8'hFF);
        rd(OFS_TRIGGER_LEVEL, 8'h01);
        rd(OFS_PIN_DIRECTION, 8'hFF);
        rd(OFS_MODEM_STATUS, 8'h30);
    endtask : reset_values
    task automatic flow_chars_and_reset_pin;
        for (int i = 0; i < 4; i++) wr(OFS_RESUME_ONE + 5'(i), 8'(8'h11 * (i + 1)));
        for (int i = 0; i < 4; i++) rd(OFS_RESUME_ONE + 5'(i), 8'(8'h11 * (i + 1)));
        wr(OFS_DIV_LOW, 8'h5A);
        wr(OFS_DIV_HIGH, 8'hA5);
        wr(OFS_LINE_STATUS, 8'h00);
        wr(5'h1D, 8'h77);
        // Drive both modem outputs low so the reset pin has something to restore.
        wr(OFS_MODEM_CTRL, 8'h03);
        #1;
        check({6'h0, rtsN, dtrN}, 8'h00);
        srst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        #1;
        check({6'h0, rtsN, dtrN}, 8'h03);
        rd(OFS_DIV_LOW, 8'h5A);
        rd(OFS_DIV_HIGH, 8'hA5);
        rd(OFS_PAUSE_TWO, 8'h00);
        rd(OFS_LINE_STATUS, RST_LINE_STATUS);
        rd(5'h1D, 8'h00);
    endtask : flow_chars_and_reset_pin
    task automatic auto_cts;
        pauseReq <= 1'b1;
        // A busy transmitter line shows that the halt really forces the idle level.
        txSerialIn <= 1'b0;
        wait_settle(4);
        check({7'h0, txHalt}, 8'h00);
        rd(OFS_MODEM_STATUS, 8'h21);
        @(posedge clk_sys);
        wr(OFS_ENH_FEATURE, 8'h80);
        wait_settle(2);
        check({6'h0, txHalt, serialTx}, 8'h03);
        @(posedge clk_sys);
        txCharBoundary <= 1'b0;
        pauseReq <= 1'b0;
        wait_settle(4);
        check({7'h0, txHalt}, 8'h01);
        @(posedge clk_sys);
        txCharBoundary <= 1'b1;
        wait_settle(3);
        check({6'h0, txHalt, serialTx}, 8'h00);
        @(posedge clk_sys);
        txSerialIn <= 1'b1;
        wr(OFS_ENH_FEATURE, 8'h00);
    endtask : auto_cts
    task automatic rx_char(input logic [7:0] d, input logic [7:0] exp);
        rxData <= d;
        rxValid <= 1'b1;
        @(posedge clk_sys);
        rxValid <= 1'b0;
        #1;
        check({7'h0, addrMatch}, exp);
        @(posedge clk_sys);
    endtask : rx_char
    task automatic addr_match;
        wr(OFS_SPECIAL_FUNC, 8'h01);
        wr(OFS_PAUSE_TWO, 8'h3C);
        rx_char(8'h3C, 8'h01);
        rx_char(8'h3D, 8'h00);
        wr(OFS_SPECIAL_FUNC, 8'h00);
        rx_char(8'h3C, 8'h00);
    endtask : addr_match
    task automatic pins;
        wr(OFS_PIN_DIRECTION, 8'h0F);
        wr(OFS_PIN_TRISTATE, 8'h30);
        wr(OFS_PIN_LEVEL, 8'hA5);
        wait_settle(2);
        check(pinOe, 8'hC0);
        check(pinOut, 8'hA5);
        @(posedge clk_sys);
        rd(OFS_PIN_LEVEL, 8'h06);
        wr(OFS_PIN_POLARITY, 8'h02);
        rd(OFS_PIN_LEVEL, 8'h04);
        wr(OFS_PIN_IRQ_EN, 8'h03);
        wr(OFS_PIN_EVT_MASK, 8'h07);
        pinIn <= 8'h01;
        repeat (3) @(posedge clk_sys);
        pinIn <= 8'h05;
        repeat (3) @(posedge clk_sys);
        rd(OFS_PIN_EVT_STATUS, 8'h03);
        #1;
        check({7'h0, irq}, 8'h01);
        @(posedge clk_sys);
        wr(OFS_PIN_EVT_MASK, 8'h00);
        wait_settle(2);
        check({7'h0, irq}, 8'h00);
        @(posedge clk_sys);
        wr(OFS_PIN_EVT_MASK, 8'h03);
        wait_settle(2);
        check({7'h0, irq}, 8'h01);
        @(posedge clk_sys);
        wr(OFS_PIN_EVT_STATUS, 8'h03);
        wait_settle(2);
        check({6'h0, irq, irqN}, 8'h01);
        @(posedge clk_sys);
        wr(OFS_PIN_TRISTATE, 8'hFF);
        wr(OFS_PIN_DIRECTION, 8'hFF);
        wait_settle(2);
        check(pinOe, 8'h00);
        @(posedge clk_sys);
    endtask : pins
    initial
    begin
        repeat (12) @(posedge clk_sys);
        srst <= 1'b0;
        pwrOnRst <= 1'b0;
        @(posedge clk_sys);
        reset_values();
        flow_chars_and_reset_pin();
        auto_cts();
        addr_match();
        pins();
        report_and_stop();
    end
endmodule : uart_gpio_flow_reset_config_bench
`default_nettype wire

// ### testbench/ugf_cts_peer.sv
`timescale 1ns/10ps
`default_nettype none
module ugf_cts_peer
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic pauseReq,
    output logic ctsN
);
    // The peer answers a pause request one cycle late, as a real far end would.
    always_ff @(posedge clk_sys)
    begin
        ctsN <= srst ? 1'b0 : pauseReq;
    end
endmodule : ugf_cts_peer
`default_nettype wire

// ### testbench/ugf_top_chk.sv
`timescale 1ns/10ps
`default_nettype none
module ugf_top_chk
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic pwrOnRst,
    input wire logic [ugf_pkg::ADDR_W-1:0] regAddr,
    input wire logic [ugf_pkg::DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [ugf_pkg::DATA_W-1:0] regRdData,
    input wire logic ctsN,
    input wire logic txCharBoundary,
    input wire logic rxValid,
    input wire logic serialTx,
    input wire logic txHalt,
    input wire logic rtsN,
    input wire logic dtrN,
    input wire logic irq,
    input wire logic irqN,
    input wire logic addrMatch,
    input wire logic [ugf_pkg::PIN_NUM-1:0] pinOe
);
    import ugf_pkg::*;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst || pwrOnRst);
    serial_halt_a: assert property (txHalt |=> serialTx)
        else $error("serial line not idle while halted");
    halt_release_a: assert property (txCharBoundary && !ctsN |=> !txHalt)
        else $error("halt kept with clear-to-send low");
    // The halt may only move between characters, never mid-frame.
    halt_hold_a: assert property (!txCharBoundary |=> $stable(txHalt))
        else $error("halt changed inside a character");
    reset_outs_a: assert property ($fell(srst) |-> serialTx && rtsN && dtrN && irqN)
        else $error("output not high after reset");
    irq_pair_a: assert property (irqN == !irq)
        else $error("interrupt outputs disagree");
    match_cause_a: assert property (addrMatch |-> $past(rxValid))
        else $error("address match without a character");
    rd_idle_a: assert property (!$past(regRd) |-> regRdData == 8'h00)
        else $error("read data outside read slot");
    tri_float_a: assert property (regWr && regAddr == OFS_PIN_TRISTATE && regWrData == 8'hFF
        |-> ##2 pinOe == 8'h00)
        else $error("tristated pin still driven");
    dir_input_a: assert property (regWr && regAddr == OFS_PIN_DIRECTION && regWrData == 8'hFF
        |-> ##2 pinOe == 8'h00)
        else $error("input pin still driven");
    lsr_const_a: assert property (regRd && regAddr == OFS_LINE_STATUS
        |=> regRdData == RST_LINE_STATUS)
        else $error("line status value wrong");
    unmapped_rd_a: assert property (regRd && regAddr > OFS_PIN_EVT_MASK |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    cover property (txHalt);
    cover property (addrMatch);
    cover property (irq);
endmodule : ugf_top_chk
bind ugf_top ugf_top_chk u_chk (.clk_sys, .srst, .pwrOnRst, .regAddr, .regWrData, .regWr,
    .regRd, .regRdData, .ctsN, .txCharBoundary, .rxValid, .serialTx, .txHalt, .rtsN, .dtrN,
    .irq, .irqN, .addrMatch, .pinOe);
`default_nettype wire
